/* rtl/fsc_regs.vh */
/*
 * constants of the flash status and configure register block: opcodes,
 * status and configure field positions, reset values, cycle counts.
 * assumes it is included once per compile unit by its bare name.
 */
// Behaviour
// - opcode 05 returns low status byte
// - opcode 35 returns high status byte
// - status reads answered even while busy
// - host clocks read; IO1 to IO3 ignored
// - busy flag set during program/erase/write
// - write latch gates status write, program, erase
// - block protect field refuses protected writes
// - block protect changes only outside hardware lock
// - chip erase only when nothing protected
// - guard 00 writes allowed with latch set
// - guard 01 locks when protect pin low, quad off
// - guard 10 locks until power cycle
// - guard 11 locks status permanently
// - quad enable turns pins into data lines
// - otp lock bits set once, never clear
// - complement bit joins block protect selection
// - suspend flags set by suspend, cleared by resume
// - suspend 75/B0 and resume 7A/30 opcodes
// - opcode 15 returns configure byte anytime
// - configure bit 7 dual page, rest reserved
// - dual page picks 256 or 512 page wrap
// - dual page erase wipes 512-byte double page
// - latch cleared at power-up and completions
// - opcode 06 sets latch, 04 clears it
`ifndef FSC_REGS_VH
`define FSC_REGS_VH

`define FSC_OP_RD_STAT_LO   8'h05
`define FSC_OP_RD_STAT_HI   8'h35
`define FSC_OP_RD_CFG       8'h15
`define FSC_OP_WR_STAT      8'h01
`define FSC_OP_WR_CFG       8'h31
`define FSC_OP_WR_EN        8'h06
`define FSC_OP_WR_DIS       8'h04
`define FSC_OP_PAGE_WRITE   8'h02
`define FSC_OP_PAGE_WIPE    8'h81
`define FSC_OP_SECT_WIPE    8'h20
`define FSC_OP_BLK32_WIPE   8'h52
`define FSC_OP_BLK_WIPE     8'hD8
`define FSC_OP_CHIP_WIPE    8'hC7
`define FSC_OP_ERASE_SUSP   8'h75
`define FSC_OP_PROG_SUSP    8'hB0
`define FSC_OP_ERASE_RES    8'h7A
`define FSC_OP_PROG_RES     8'h30
`define FSC_OP_SOFT_RESET   8'h99

`define FSC_ST_BUSY         0
`define FSC_ST_LATCH        1
`define FSC_ST_BP_LO        2
`define FSC_ST_BP_HI        6
`define FSC_ST_GUARD_LO     7
`define FSC_ST_GUARD_HI     8
`define FSC_ST_QUAD         9
`define FSC_ST_PROG_SUSP    10
`define FSC_ST_LOCK_LO      11
`define FSC_ST_LOCK_HI      13
`define FSC_ST_CMP          14
`define FSC_ST_ERASE_SUSP   15
`define FSC_CFG_DUAL_PAGE   7

`define FSC_STATUS_RESET    16'h0000
`define FSC_CONFIG_RESET    8'h00
`define FSC_NV_WR_MASK      16'h7BFC

`define FSC_PAGE_SMALL      10'h100
`define FSC_PAGE_LARGE      10'h200

// busy time of a self-timed status write, in microseconds
`define FSC_T_WRITE_US      2
`define FSC_CLK_MHZ         100
`define FSC_T_WRITE_CYC     (`FSC_T_WRITE_US * `FSC_CLK_MHZ)

`endif

/* rtl/fsc_status_config.v */
/*
 * status and configure register logic of a serial flash: decodes the
 * opcode on the serial input, answers status and configure reads, keeps
 * the write latch, protect guard, lock, suspend and dual-page state and
 * grants or refuses program and erase requests.
 * assumes the host runs spi mode 0 with sclk well below i_clk / 4; the
 * array engine outside reports busy and completion on i_clk.
 */
`timescale 1ns/100ps
`include "fsc_regs.vh"

module fsc_status_config #(
    parameter T_WRITE_CYC = `FSC_T_WRITE_CYC
) (
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_cs_n,
    input  wire        i_sclk,
    input  wire        i_si,
    input  wire        i_wp_n,
    input  wire        i_power_up,
    input  wire        i_array_busy,
    input  wire        i_array_done,
    input  wire [4:0]  i_target_region,
    output reg         o_so,
    output reg         o_so_oe,
    output reg         o_quad_lines_enable,
    output reg  [9:0]  o_page_size,
    output reg         o_page_wrap_256,
    output reg         o_wipe_double_page,
    output reg         o_array_grant,
    output reg         o_array_refuse,
    output reg  [15:0] o_status,
    output reg  [7:0]  o_config
);

    // *****************************************************************
    // link input synchronisers and edge detection
    // *****************************************************************
    reg [1:0] cs_sync;
    reg [1:0] sclk_sync;
    reg [1:0] si_sync;
    reg [1:0] wp_sync;
    reg       sclk_prev;
    reg       cs_prev;

    always @(posedge i_clk) begin
        if (i_srst) begin
            cs_sync   <= 2'h3;
            sclk_sync <= 2'h0;
            si_sync   <= 2'h0;
            wp_sync   <= 2'h3;
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            cs_sync   <= {cs_sync[0], i_cs_n};
            sclk_sync <= {sclk_sync[0], i_sclk};
            si_sync   <= {si_sync[0], i_si};
            wp_sync   <= {wp_sync[0], i_wp_n};
            sclk_prev <= sclk_sync[1];
            cs_prev   <= cs_sync[1];
        end
    end

    wire cs_low   = ~cs_sync[1];
    wire sclk_ris = cs_low & sclk_sync[1] & ~sclk_prev;
    wire sclk_fal = cs_low & ~sclk_sync[1] & sclk_prev;
    wire cs_rise  = cs_sync[1] & ~cs_prev;
    // with quad enabled the protect pin is a data line, not a guard
    wire wp_level = o_quad_lines_enable ? 1'b1 : wp_sync[1];

    // *****************************************************************
    // frame shifter
    // *****************************************************************
    reg [7:0]  opcode;
    reg [15:0] data_in;
    reg [5:0]  bit_cnt;
    reg [7:0]  shift_out;
    reg [2:0]  out_cnt;
    reg        reading;

    // only io0 is sampled; io1 to io3 play no part in a read
    always @(posedge i_clk) begin
        if (i_srst | cs_rise) begin
            opcode  <= 8'h00;
            data_in <= 16'h0000;
            bit_cnt <= 6'h00;
        end else if (sclk_ris) begin
            if (bit_cnt < 6'h08) begin
                opcode <= {opcode[6:0], si_sync[1]};
            end else begin
                data_in <= {data_in[14:0], si_sync[1]};
            end
            if (bit_cnt != 6'h3F) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end
    end

    wire op_ready = (bit_cnt == 6'h08);

    reg [7:0] read_byte;
    always @* begin
        case (opcode)
            `FSC_OP_RD_STAT_LO: read_byte = o_status[7:0];
            `FSC_OP_RD_STAT_HI: read_byte = o_status[15:8];
            `FSC_OP_RD_CFG:     read_byte = o_config;
            default:            read_byte = 8'h00;
        endcase
    end

    wire is_read = (opcode == `FSC_OP_RD_STAT_LO) |
                   (opcode == `FSC_OP_RD_STAT_HI) |
                   (opcode == `FSC_OP_RD_CFG);

    // reads never look at busy, so they are answered mid-operation
    always @(posedge i_clk) begin
        if (i_srst | ~cs_low) begin
            reading   <= 1'b0;
            shift_out <= 8'h00;
            out_cnt   <= 3'h0;
            o_so      <= 1'b0;
            o_so_oe   <= 1'b0;
        end else if (sclk_fal & op_ready & ~reading & is_read) begin
            reading   <= 1'b1;
            o_so_oe   <= 1'b1;
            o_so      <= read_byte[7];
            shift_out <= {read_byte[6:0], 1'b0};
            out_cnt   <= 3'h1;
        end else if (sclk_fal & reading) begin
            // each new byte re-samples live state, msb first
            if (out_cnt == 3'h0) begin
                o_so      <= read_byte[7];
                shift_out <= {read_byte[6:0], 1'b0};
            end else begin
                o_so      <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
            out_cnt <= out_cnt + 3'h1;
        end
    end

    // *****************************************************************
    // protection decode
    // *****************************************************************
    wire [1:0] guard = {o_status[`FSC_ST_GUARD_HI],
                        o_status[`FSC_ST_GUARD_LO]};
    wire [4:0] bp    = o_status[`FSC_ST_BP_HI:`FSC_ST_BP_LO];
    wire       cmpl  = o_status[`FSC_ST_CMP];
    wire       latch = o_status[`FSC_ST_LATCH];
    wire       busy  = o_status[`FSC_ST_BUSY];

    reg sr_locked;
    always @* begin
        case (guard)
            2'h0:    sr_locked = 1'b0;
            2'h1:    sr_locked = ~wp_level;
            2'h2:    sr_locked = 1'b1;
            2'h3:    sr_locked = 1'b1;
            default: sr_locked = 1'b1;
        endcase
    end

    // the region map is simplified: the target's region code is
    // compared against the field, complement flips the sense
    wire in_field  = (bp != 5'h00) & (i_target_region <= bp);
    wire protected_hit = cmpl ? ~in_field : in_field;
    wire none_protected = cmpl ? 1'b0 : (bp == 5'h00);

    // *****************************************************************
    // command execution at chip-select release
    // *****************************************************************
    wire whole_op = cs_rise & (bit_cnt == 6'h08);
    wire sr_len_ok = (bit_cnt == 6'h10) | (bit_cnt == 6'h18);
    wire is_wipe = (opcode == `FSC_OP_PAGE_WRITE) |
                   (opcode == `FSC_OP_PAGE_WIPE) |
                   (opcode == `FSC_OP_SECT_WIPE) |
                   (opcode == `FSC_OP_BLK32_WIPE) |
                   (opcode == `FSC_OP_BLK_WIPE);
    wire is_chip = (opcode == `FSC_OP_CHIP_WIPE);
    wire arr_req = cs_rise & (bit_cnt >= 6'h08) & (is_wipe | is_chip) & ~busy;
    wire arr_ok  = latch & (is_chip ? none_protected : ~protected_hit);

    wire wr_stat = cs_rise & sr_len_ok & ~busy & latch & ~sr_locked &
                   (opcode == `FSC_OP_WR_STAT);
    wire wr_cfg  = cs_rise & (bit_cnt == 6'h10) & ~busy & latch &
                   (opcode == `FSC_OP_WR_CFG);
    wire [15:0] new_sr = (bit_cnt == 6'h10) ? {8'h00, data_in[7:0]} :
                         {data_in[7:0], data_in[15:8]};

    reg [31:0] wr_timer;
    reg        sr_writing;

    // non-volatile part of status plus the volatile flags
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_status       <= `FSC_STATUS_RESET;
            o_config       <= `FSC_CONFIG_RESET;
            wr_timer       <= 32'h0;
            sr_writing     <= 1'b0;
            o_array_grant  <= 1'b0;
            o_array_refuse <= 1'b0;
        end else begin
            o_array_grant  <= arr_req & arr_ok;
            o_array_refuse <= arr_req & ~arr_ok;
            o_status[`FSC_ST_BUSY] <= i_array_busy | sr_writing;
            if (i_power_up) begin
                // guard 10 drops back to 00 at a power cycle
                if (guard == 2'h2) begin
                    o_status[`FSC_ST_GUARD_HI] <= 1'b0;
                    o_status[`FSC_ST_GUARD_LO] <= 1'b0;
                end
                o_status[`FSC_ST_LATCH]      <= 1'b0;
                o_status[`FSC_ST_ERASE_SUSP] <= 1'b0;
                o_status[`FSC_ST_PROG_SUSP]  <= 1'b0;
            end else begin
                if (wr_stat) begin
                    sr_writing <= 1'b1;
                    wr_timer   <= T_WRITE_CYC;
                    o_status[`FSC_ST_GUARD_LO] <= new_sr[7];
                    o_status[`FSC_ST_GUARD_HI] <= new_sr[8];
                    o_status[`FSC_ST_QUAD]     <= new_sr[9];
                    o_status[`FSC_ST_CMP]      <= new_sr[14];
                    // sr_locked already bars the hardware-protected case
                    o_status[`FSC_ST_BP_HI:`FSC_ST_BP_LO] <=
                        new_sr[6:2];
                    // lock bits only ever gain ones
                    o_status[`FSC_ST_LOCK_HI:`FSC_ST_LOCK_LO] <=
                        o_status[`FSC_ST_LOCK_HI:`FSC_ST_LOCK_LO] |
                        new_sr[13:11];
                end else if (wr_cfg) begin
                    sr_writing <= 1'b1;
                    wr_timer   <= T_WRITE_CYC;
                    o_config   <= {data_in[7], 7'h00};
                end else if (sr_writing) begin
                    if (wr_timer == 32'h1) begin
                        sr_writing <= 1'b0;
                        o_status[`FSC_ST_LATCH] <= 1'b0;
                    end
                    wr_timer <= wr_timer - 32'h1;
                end
                // completion clears the latch first so that a write
                // enable decoded in the same cycle wins
                if (i_array_done) begin
                    o_status[`FSC_ST_LATCH] <= 1'b0;
                end
                if (whole_op) begin
                    case (opcode)
                        `FSC_OP_WR_EN:
                            o_status[`FSC_ST_LATCH] <= 1'b1;
                        `FSC_OP_WR_DIS, `FSC_OP_SOFT_RESET:
                            o_status[`FSC_ST_LATCH] <= 1'b0;
                        `FSC_OP_ERASE_SUSP:
                            o_status[`FSC_ST_ERASE_SUSP] <= 1'b1;
                        `FSC_OP_PROG_SUSP:
                            o_status[`FSC_ST_PROG_SUSP] <= 1'b1;
                        `FSC_OP_ERASE_RES, `FSC_OP_PROG_RES: begin
                            o_status[`FSC_ST_ERASE_SUSP] <= 1'b0;
                            o_status[`FSC_ST_PROG_SUSP]  <= 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // *****************************************************************
    // derived outputs
    // *****************************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_quad_lines_enable <= 1'b0;
            o_page_size         <= `FSC_PAGE_SMALL;
            o_page_wrap_256     <= 1'b1;
            o_wipe_double_page  <= 1'b0;
        end else begin
            o_quad_lines_enable <= o_status[`FSC_ST_QUAD];
            o_page_size <= o_config[`FSC_CFG_DUAL_PAGE] ?
                           `FSC_PAGE_LARGE : `FSC_PAGE_SMALL;
            o_page_wrap_256    <= ~o_config[`FSC_CFG_DUAL_PAGE];
            o_wipe_double_page <= o_config[`FSC_CFG_DUAL_PAGE];
        end
    end

endmodule // fsc_status_config

/* testbench/fsc_host_model.sv */
/*
 * spi mode 0 host model that frames opcodes, write data and read bits.
 * assumes one caller at a time and sclk slow against i_clk.
 */
`timescale 1ns/100ps
// ****
// host frames
// ****
module fsc_host_model (
    input  wire i_clk,
    input  wire i_so,
    output reg  o_cs_n,
    output reg  o_sclk,
    output reg  o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si   = 1'b0;
    end
    // half of a 160 ns link period
    task half;
        begin
            repeat (8) @(posedge i_clk);
            #1;
        end
    endtask
    task frame(input [23:0] wr, input integer n_wr, input integer n_rd,
               output reg [15:0] rd);
        integer k;
        begin
            rd = 16'h0000;
            o_cs_n = 1'b0;
            for (k = 0; k < n_wr + n_rd; k = k + 1) begin
                // idle data toggles so a stale level never passes for data
                o_si = (k < n_wr) ? wr[23 - k] : ~o_si;
                half;
                o_sclk = 1'b1;
                if (k >= n_wr)
                    rd = {rd[14:0], i_so};
                half;
                o_sclk = 1'b0;
            end
            half;
            o_cs_n = 1'b1;
            half;
        end
    endtask
endmodule // fsc_host_model

/* testbench/fsc_sc_asserts.sv */
/*
 * checker of the status and configure block on its ports.
 * assumes it is bound to every instance of the block.
 */
`timescale 1ns/100ps
// ****
// checker
// ****
module fsc_sc_asserts #(
    parameter T_WRITE_CYC = 5
) (
    input wire        i_clk,
    input wire        i_srst,
    input wire        i_cs_n,
    input wire        i_power_up,
    input wire        i_array_busy,
    input wire        o_so_oe,
    input wire        o_quad_lines_enable,
    input wire [9:0]  o_page_size,
    input wire        o_page_wrap_256,
    input wire        o_wipe_double_page,
    input wire        o_array_grant,
    input wire        o_array_refuse,
    input wire [15:0] o_status,
    input wire [7:0]  o_config
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_quad_pins: assert property (
        $stable(o_status[9]) |-> o_quad_lines_enable == o_status[9])
        else $error("quad output differs from status");
    a_page_size: assert property (
        $stable(o_config[7]) |-> o_page_wrap_256 == !o_config[7] &&
        o_page_size == (o_config[7] ? 10'h200 : 10'h100))
        else $error("page size does not follow dual page");
    a_double_wipe: assert property (
        $stable(o_config[7]) |-> o_wipe_double_page == o_config[7])
        else $error("double page wipe wrong");
    a_one_verdict: assert property (
        !(o_array_grant && o_array_refuse))
        else $error("grant and refuse together");
    a_grant_latch: assert property (
        o_array_grant |-> $past(o_status[1]))
        else $error("grant without write latch");
    a_busy_flag: assert property (
        i_array_busy [*3] |-> o_status[0])
        else $error("busy flag low while array busy");
    a_lock_sticky: assert property (
        ($past(o_status[13:11]) & ~o_status[13:11]) == 3'h0)
        else $error("lock bit cleared");
    a_so_release: assert property (
        $rose(i_cs_n) |-> ##[1:4] !o_so_oe)
        else $error("serial out still driven");
    a_power_clear: assert property (
        i_power_up |-> ##[1:2] !o_status[15] && !o_status[10] &&
        o_status[8:7] != 2'b10)
        else $error("power cycle left flags set");
    c_grant: cover property (o_array_grant);
    c_refuse: cover property (o_array_refuse);
    c_read: cover property ($rose(o_so_oe));
endmodule // fsc_sc_asserts
bind fsc_status_config fsc_sc_asserts #(.T_WRITE_CYC(T_WRITE_CYC)) i_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
    .i_power_up(i_power_up), .i_array_busy(i_array_busy),
    .o_so_oe(o_so_oe), .o_quad_lines_enable(o_quad_lines_enable),
    .o_page_size(o_page_size), .o_page_wrap_256(o_page_wrap_256),
    .o_wipe_double_page(o_wipe_double_page),
    .o_array_grant(o_array_grant), .o_array_refuse(o_array_refuse),
    .o_status(o_status), .o_config(o_config));

/* testbench/tb_top.sv */
/*
 * top bench: host model, block under test and scenario tasks.
 * assumes the host model and checker compile first.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    err_count++; $display("Error %0t: got %h want %h", $time, a, b); \
    end end
// ****
// bench
// ****
module tb_top;
    reg         i_clk = 1'b0;
    reg         i_srst = 1'b1;
    reg         i_wp_n = 1'b1;
    reg         i_power_up = 1'b0;
    reg         i_array_busy = 1'b0;
    reg         i_array_done = 1'b0;
    reg  [4:0]  i_target_region = 5'h00;
    wire        cs_n, sclk, si, so, oe, quad, wrap, dbl, gnt, rfs;
    wire [9:0]  psize;
    wire [15:0] stat;
    wire [7:0]  cfg;
    reg  [15:0] rd;
    integer     err_count = 0, total_checks = 0;
    integer     n_gnt = 0, n_ref = 0, cyc = 0;
    initial forever #5 i_clk = ~i_clk;
    fsc_host_model i_host (.i_clk(i_clk), .i_so(so), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_si(si));
    fsc_status_config #(.T_WRITE_CYC(5)) i_dut (.i_clk(i_clk),
        .i_srst(i_srst), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
        .i_wp_n(i_wp_n), .i_power_up(i_power_up),
        .i_array_busy(i_array_busy), .i_array_done(i_array_done),
        .i_target_region(i_target_region), .o_so(so), .o_so_oe(oe),
        .o_quad_lines_enable(quad), .o_page_size(psize),
        .o_page_wrap_256(wrap), .o_wipe_double_page(dbl),
        .o_array_grant(gnt), .o_array_refuse(rfs), .o_status(stat),
        .o_config(cfg));
    task finish_test;
        begin
            if (err_count == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // whole run needs about 11300 cycles
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (gnt === 1'b1) n_gnt = n_gnt + 1;
        if (rfs === 1'b1) n_ref = n_ref + 1;
        if (cyc == 40000) begin
            err_count = err_count + 1;
            finish_test;
        end
    end
    task op(input [7:0] c);
        i_host.frame({c, 16'h0000}, 8, 0, rd);
    endtask
    task rdr(input [7:0] c, input integer n);
        i_host.frame({c, 16'h0000}, 8, n, rd);
    endtask
    task wrs(input [7:0] c, input [15:0] d, input integer n);
        begin
            op(8'h06);
            i_host.frame({c, d}, 8 + n, 0, rd);
            repeat (20) @(posedge i_clk);
            #1;
        end
    endtask
    task pgm(input [7:0] c, input [4:0] r, input wen, input ok);
        integer g, f;
        begin
            g = n_gnt;
            f = n_ref;
            i_target_region = r;
            if (wen) op(8'h06);
            op(c);
            `CHK(n_gnt - g, ok ? 1 : 0)
            `CHK(n_ref - f, ok ? 0 : 1)
        end
    endtask
    task pulse_done;
        begin
            i_array_done = 1'b1;
            @(posedge i_clk);
            #1 i_array_done = 1'b0;
            repeat (3) @(posedge i_clk);
            #1;
        end
    endtask
    task pulse_power;
        begin
            i_power_up = 1'b1;
            @(posedge i_clk);
            #1 i_power_up = 1'b0;
            repeat (3) @(posedge i_clk);
            #1;
        end
    endtask
    task t_reset;
        begin
            `CHK(stat, 16'h0000)
            `CHK(cfg, 8'h00)
            `CHK(psize, 10'h100)
            `CHK(wrap, 1'b1)
        end
    endtask
    task t_latch;
        begin
            op(8'h06);
            rdr(8'h05, 16);
            `CHK(rd, 16'h0202)
            op(8'h04);
            rdr(8'h05, 8);
            `CHK(rd, 16'h0000)
        end
    endtask
    task t_write;
        begin
            wrs(8'h01, 16'h0C0A, 16);
            rdr(8'h35, 8);
            `CHK(rd, 16'h000A)
            `CHK(quad, 1'b1)
            rdr(8'h05, 8);
            `CHK(rd, 16'h000C)
            wrs(8'h01, 16'h0C00, 16);
            `CHK(stat, 16'h080C)
        end
    endtask
    task t_busy;
        begin
            i_array_busy = 1'b1;
            rdr(8'h05, 8);
            `CHK(rd, 16'h000D)
            rdr(8'h15, 8);
            `CHK(rd, 16'h0000)
            i_array_busy = 1'b0;
            rdr(8'h05, 8);
            `CHK(rd, 16'h000C)
        end
    endtask
    task t_protect;
        begin
            pgm(8'h02, 5'h02, 1'b1, 1'b0);
            pgm(8'h81, 5'h03, 1'b1, 1'b0);
            op(8'h04);
            pgm(8'h02, 5'h05, 1'b0, 1'b0);
            pgm(8'h20, 5'h05, 1'b1, 1'b1);
            pulse_done;
            `CHK(stat[1], 1'b0)
            pgm(8'hC7, 5'h1F, 1'b1, 1'b0);
            op(8'h04);
        end
    endtask
    task t_susp;
        integer k;
        reg [31:0] t_op, t_hi;
        begin
            t_op = 32'h7530B07A;
            t_hi = 32'h88080C08;
            for (k = 3; k >= 0; k = k - 1) begin
                op(t_op[8*k +: 8]);
                `CHK(stat[15:8], t_hi[8*k +: 8])
            end
        end
    endtask
    task t_guard;
        begin
            wrs(8'h01, 16'h8C08, 16);
            i_wp_n = 1'b0;
            wrs(8'h01, 16'h0008, 16);
            `CHK(stat & 16'hFFFD, 16'h088C)
            i_wp_n = 1'b1;
            wrs(8'h01, 16'h1009, 16);
            `CHK(stat & 16'hFFFD, 16'h0910)
            wrs(8'h01, 16'h0008, 16);
            `CHK(stat & 16'hFFFD, 16'h0910)
            op(8'h75);
            pulse_power;
            `CHK(stat, 16'h0810)
            wrs(8'h01, 16'h1040, 16);
            `CHK(stat, 16'h4810)
            pgm(8'h02, 5'h02, 1'b1, 1'b1);
            pgm(8'h02, 5'h05, 1'b1, 1'b0);
            wrs(8'h01, 16'h8101, 16);
            pgm(8'hC7, 5'h00, 1'b1, 1'b1);
            wrs(8'h01, 16'h0000, 16);
            pulse_power;
            `CHK(stat, 16'h0980)
        end
    endtask
    task t_config;
        begin
            wrs(8'h31, 16'hFF00, 8);
            `CHK(cfg, 8'h80)
            `CHK(psize, 10'h200)
            `CHK(wrap, 1'b0)
            `CHK(dbl, 1'b1)
            rdr(8'h15, 8);
            `CHK(rd, 16'h0080)
        end
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        #1 i_srst = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        t_reset;
        t_latch;
        t_write;
        t_busy;
        t_protect;
        t_susp;
        t_guard;
        t_config;
        finish_test;
    end
endmodule // tb_top
